// File: pkg/ots_pkg.sv
package ots_pkg;
  // timing: core clock and pickup frequency window
  localparam int OTS_CLK_HZ = 20_000_000;
  localparam int OTS_FMAX_HZ = 24950;
  localparam int OTS_FMIN_HZ = 100;
  localparam int OTS_MIN_PER_CYC = OTS_CLK_HZ / OTS_FMAX_HZ;
  localparam int OTS_TIMEOUT_CYC = OTS_CLK_HZ / OTS_FMIN_HZ;
  localparam int OTS_CNT_W = 18;
  localparam int OTS_DIV_STEPS = 32;
  // rpm = 60 * clk_hz / (period_cycles * teeth)
  localparam logic [31:0] OTS_RPM_NUM = 32'(60 * OTS_CLK_HZ);
  localparam logic [15:0] OTS_RES_KNEE = 16'h4000;
  localparam logic [31:0] OTS_REC_NUM = 32'h0000_03E6;
  localparam logic [31:0] OTS_REC_DEN = 32'h0000_03E8;
  localparam int OTS_AO_W = 12;
  localparam logic [15:0] OTS_AO_MAX = 16'h0FFF;
  // register offsets
  localparam logic [7:0] OTS_CTRL_OFS = 8'h00;
  localparam logic [7:0] OTS_STAT_OFS = 8'h04;
  localparam logic [7:0] OTS_IST_OFS = 8'h08;
  localparam logic [7:0] OTS_IMSK_OFS = 8'h0C;
  localparam logic [7:0] OTS_SPD_OFS = 8'h10;
  localparam logic [7:0] OTS_TEETH_OFS = 8'h18;
  localparam logic [7:0] OTS_MAXS_OFS = 8'h20;
  localparam logic [7:0] OTS_TRIP_OFS = 8'h28;
  localparam logic [7:0] OTS_FAIL_OFS = 8'h2C;
  localparam logic [7:0] OTS_DEVR_OFS = 8'h30;
  localparam logic [7:0] OTS_TFS_OFS = 8'h34;
  localparam logic [7:0] OTS_SWSP_OFS = 8'h40;
  localparam logic [7:0] OTS_SWHY_OFS = 8'h60;
  localparam logic [7:0] OTS_AOLO_OFS = 8'h80;
  localparam logic [7:0] OTS_AOGN_OFS = 8'h90;
  // field positions
  localparam int OTS_CTRL_CFG = 0;
  localparam int OTS_ST_TRIP = 0;
  localparam int OTS_ST_OS = 1;
  localparam int OTS_ST_DUAL = 2;
  localparam int OTS_ST_FAIL = 3;
  localparam int OTS_ST_DEV = 5;
  localparam int OTS_ST_SW = 7;
  localparam int OTS_ST_OVR = 13;
  localparam int OTS_ST_WARN = 14;
  localparam int OTS_IRQ_TRIP = 0;
  localparam int OTS_IRQ_FAIL = 1;
  localparam int OTS_IRQ_RST = 3;
  localparam int OTS_IRQ_DEV = 4;
  localparam int OTS_IRQ_W = 5;
  // reset values
  localparam logic [7:0] OTS_TEETH_RST = 8'h3C;
  localparam logic [15:0] OTS_MAXS_RST = 16'h4E20;
  localparam logic [15:0] OTS_TRIP_RST = 16'h4650;
  localparam logic [15:0] OTS_FAIL_RST = 16'h01F4;
  localparam logic [15:0] OTS_DEVR_RST = 16'h0064;
  localparam logic [15:0] OTS_TFS_RST = 16'h4268;
  localparam logic [15:0] OTS_SWSP_RST = 16'hFFFF;
endpackage : ots_pkg

// File: pkg/ots_spd_if.sv
`timescale 1ns/100ps
`default_nettype none
// one pickup channel: settings in, measured speed out
interface ots_spd_if;
  logic [7:0] teeth;
  logic [15:0] max_speed;
  logic [15:0] speed;
  logic fresh;
  modport meter (input teeth, input max_speed, output speed, output fresh);
  modport core (output teeth, output max_speed, input speed, input fresh);
endinterface : ots_spd_if
`default_nettype wire

// File: core/ots_speed_meter.sv
`timescale 1ns/100ps
`default_nettype none
module ots_speed_meter
  import ots_pkg::*;
#(
  parameter int TIMEOUT_CYC = OTS_TIMEOUT_CYC
)(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic pickup_in,
  ots_spd_if.meter spd
);
  localparam logic [OTS_CNT_W-1:0] TO = OTS_CNT_W'(TIMEOUT_CYC);
  localparam logic [OTS_CNT_W-1:0] MINP = OTS_CNT_W'(OTS_MIN_PER_CYC);
  logic [2:0] sync_q;
  logic [OTS_CNT_W-1:0] cnt_q;
  logic busy_q;
  logic [5:0] step_q;
  logic [31:0] quo_q;
  logic [32:0] rem_q;
  logic [31:0] dvs_q;
  logic [32:0] rem_sh;
  logic ge;
  logic [31:0] q_fin;
  logic [15:0] res_mask;
  logic take;

  // rising edge seen only after two sync stages
  assign take = sync_q[1] & ~sync_q[2] & (cnt_q >= MINP);
  assign rem_sh = {rem_q[31:0], quo_q[31]};
  assign ge = rem_sh >= {1'b0, dvs_q};
  assign q_fin = {quo_q[30:0], ge};
  assign res_mask = (spd.max_speed >= OTS_RES_KNEE) ? 16'hFFFE : 16'hFFFF;

  // pickup pin into the core domain
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      sync_q <= 3'h0;
    else
      sync_q <= {sync_q[1:0], pickup_in};
  end

  // period count, glitch floor, 100 Hz timeout
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_q <= TO;
    else if (take)
      cnt_q <= '0;
    else if (cnt_q != TO)
      cnt_q <= cnt_q + 1'b1;
  end

  // rpm by long division over period times teeth
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      busy_q <= 1'b0;
      step_q <= 6'h00;
      quo_q <= 32'h0000_0000;
      rem_q <= 33'h0_0000_0000;
      dvs_q <= 32'h0000_0000;
    end
    else if (!busy_q)
    begin
      // an edge after a timeout only restarts the count
      if (take && cnt_q != TO)
      begin
        busy_q <= 1'b1;
        step_q <= 6'h00;
        quo_q <= OTS_RPM_NUM;
        rem_q <= 33'h0_0000_0000;
        dvs_q <= 32'(cnt_q + 1'b1) * 32'(spd.teeth);
      end
    end
    else
    begin
      rem_q <= ge ? rem_sh - {1'b0, dvs_q} : rem_sh;
      quo_q <= q_fin;
      step_q <= step_q + 6'h01;
      if (step_q == 6'(OTS_DIV_STEPS - 1))
        busy_q <= 1'b0;
    end
  end

  // never report above the max setting
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      spd.speed <= 16'h0000;
      spd.fresh <= 1'b0;
    end
    else if (cnt_q == TO - 1'b1)
    begin
      spd.speed <= 16'h0000;
      spd.fresh <= 1'b1;
    end
    else if (busy_q && step_q == 6'(OTS_DIV_STEPS - 1))
    begin
      if (q_fin > 32'(spd.max_speed))
        spd.speed <= spd.max_speed & res_mask;
      else
        spd.speed <= q_fin[15:0] & res_mask;
      spd.fresh <= 1'b1;
    end
    else
      spd.fresh <= 1'b0;
  end

  spd_clamp_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    spd.fresh |-> spd.speed <= spd.max_speed)
    else $error("speed above max setting");
endmodule : ots_speed_meter
`default_nettype wire

// File: core/ots_top.sv
`timescale 1ns/100ps
`default_nettype none
module ots_top
  import ots_pkg::*;
#(
  parameter int TIMEOUT_CYC = OTS_TIMEOUT_CYC,
  parameter int N_SW = 6,
  parameter int N_AO = 4
)(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [1:0] speed_pickup_in,
  input wire logic reset_sw_in,
  input wire logic override_sw_in,
  input wire logic cpu_ok_in,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic trip_relay,
  output logic trip_ind,
  output logic [1:0] fail_relay,
  output logic [N_SW-1:0] sw_relay,
  output logic [1:0] dev_relay,
  output logic [N_AO-1:0][OTS_AO_W-1:0] ao_code,
  output logic irq
);
  // settings
  logic cfg_mode_q;
  logic [7:0] teeth_q [2];
  logic [15:0] maxs_q [2];
  logic [15:0] trip_sp_q;
  logic [15:0] fail_sp_q;
  logic [15:0] dev_rng_q;
  logic [15:0] tfs_q;
  logic [15:0] sw_sp_q [N_SW];
  logic [15:0] sw_hy_q [N_SW];
  logic [15:0] ao_lo_q [N_AO];
  logic [15:0] ao_gn_q [N_AO];
  logic [OTS_IRQ_W-1:0] ist_q;
  logic [OTS_IRQ_W-1:0] ist_d;
  logic [OTS_IRQ_W-1:0] imsk_q;
  logic [OTS_IRQ_W-1:0] ev;
  // discrete input sync stages
  logic [2:0] rs_q;
  logic [1:0] ov_q;
  logic [1:0] ck_q;
  logic rst_pulse;
  logic ovr;
  // alarm state
  logic os_q;
  logic os_d;
  logic os_set;
  logic dual_q;
  logic dual_d;
  logic dual_set;
  logic [1:0] fail_q;
  logic [1:0] fail_d;
  logic [1:0] fail_set;
  logic [1:0] low;
  logic [1:0] dev_d;
  logic [1:0] warn;
  logic [15:0] spd [2];
  logic [15:0] top_spd;
  logic [31:0] rd_mux;
  logic [31:0] stat;

  // one register word at base plus index
  function automatic logic reg_hit(
    input logic [7:0] a,
    input logic [7:0] base,
    input int idx
  );
    return a == base + 8'(idx * 4);
  endfunction : reg_hit

  // two pickup channels
  ots_spd_if sp_if [2] ();
  for (genvar g = 0; g < 2; g++)
  begin : g_pick
    assign sp_if[g].teeth = teeth_q[g];
    assign sp_if[g].max_speed = maxs_q[g];
    assign spd[g] = sp_if[g].speed;
    ots_speed_meter #(
      .TIMEOUT_CYC(TIMEOUT_CYC)
    ) u_meter (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .pickup_in(speed_pickup_in[g]),
      .spd(sp_if[g])
    );
  end

  // contacts and health line are pins: two flops first
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rs_q <= 3'h0;
      ov_q <= 2'h0;
      ck_q <= 2'h0;
    end
    else
    begin
      rs_q <= {rs_q[1:0], reset_sw_in};
      ov_q <= {ov_q[0], override_sw_in};
      ck_q <= {ck_q[0], cpu_ok_in};
    end
  end

  assign rst_pulse = rs_q[1] & ~rs_q[2];
  assign ovr = ov_q[1];
  assign top_spd = (spd[0] > spd[1]) ? spd[0] : spd[1];

  // settings written by software
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg_mode_q <= 1'b0;
      trip_sp_q <= OTS_TRIP_RST;
      fail_sp_q <= OTS_FAIL_RST;
      dev_rng_q <= OTS_DEVR_RST;
      tfs_q <= OTS_TFS_RST;
      imsk_q <= '0;
      for (int i = 0; i < 2; i++)
      begin
        teeth_q[i] <= OTS_TEETH_RST;
        maxs_q[i] <= OTS_MAXS_RST;
      end
      for (int i = 0; i < N_SW; i++)
      begin
        sw_sp_q[i] <= OTS_SWSP_RST;
        sw_hy_q[i] <= 16'h0000;
      end
      for (int i = 0; i < N_AO; i++)
      begin
        ao_lo_q[i] <= 16'h0000;
        ao_gn_q[i] <= 16'h0000;
      end
    end
    else if (reg_wr)
    begin
      if (reg_addr == OTS_CTRL_OFS)
        cfg_mode_q <= reg_wdata[OTS_CTRL_CFG];
      if (reg_addr == OTS_IMSK_OFS)
        imsk_q <= reg_wdata[OTS_IRQ_W-1:0];
      if (reg_addr == OTS_TRIP_OFS)
        trip_sp_q <= reg_wdata[15:0];
      if (reg_addr == OTS_FAIL_OFS)
        fail_sp_q <= reg_wdata[15:0];
      if (reg_addr == OTS_DEVR_OFS)
        dev_rng_q <= reg_wdata[15:0];
      if (reg_addr == OTS_TFS_OFS)
        tfs_q <= reg_wdata[15:0];
      for (int i = 0; i < 2; i++)
      begin
        if (reg_hit(reg_addr, OTS_TEETH_OFS, i))
          teeth_q[i] <= reg_wdata[7:0];
        if (reg_hit(reg_addr, OTS_MAXS_OFS, i))
          maxs_q[i] <= reg_wdata[15:0];
      end
      for (int i = 0; i < N_SW; i++)
      begin
        if (reg_hit(reg_addr, OTS_SWSP_OFS, i))
          sw_sp_q[i] <= reg_wdata[15:0];
        if (reg_hit(reg_addr, OTS_SWHY_OFS, i))
          sw_hy_q[i] <= reg_wdata[15:0];
      end
      for (int i = 0; i < N_AO; i++)
      begin
        if (reg_hit(reg_addr, OTS_AOLO_OFS, i))
          ao_lo_q[i] <= reg_wdata[15:0];
        if (reg_hit(reg_addr, OTS_AOGN_OFS, i))
          ao_gn_q[i] <= reg_wdata[15:0];
      end
    end
  end

  // alarm next state; every set beats its clear
  always_comb
  begin
    for (int g = 0; g < 2; g++)
    begin
      low[g] = spd[g] < fail_sp_q;
      fail_set[g] = low[g] & ~ovr;
    end
    // both low without override is a dual failure
    dual_set = fail_set[0] & fail_set[1];
    os_set = (spd[0] >= trip_sp_q) | (spd[1] >= trip_sp_q);
    for (int g = 0; g < 2; g++)
    begin
      // held until reset may clear it
      fail_d[g] = fail_set[g] |
        (fail_q[g] & ~(rst_pulse & (ovr | ~low[g])));
    end
    // dual failure clears only with override
    dual_d = dual_set | (dual_q & ~(rst_pulse & ovr));
    // overspeed clears by reset once below
    os_d = os_set | (os_q & ~rst_pulse);
  end

  // latched alarm state
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      os_q <= 1'b0;
      dual_q <= 1'b0;
      fail_q <= 2'h0;
    end
    else
    begin
      os_q <= os_d;
      dual_q <= dual_d;
      fail_q <= fail_d;
    end
  end

  // trip and failure relays; energized means healthy
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      trip_relay <= 1'b0;
      trip_ind <= 1'b0;
      fail_relay <= 2'h0;
    end
    else
    begin
      trip_relay <= ~(os_d | dual_d | cfg_mode_q | ~ck_q[1]);
      trip_ind <= os_d;
      fail_relay <= ~fail_d;
    end
  end

  // speed switches and deviation on measured speed
  always_comb
  begin
    // relay 0 when pickup one reads low
    dev_d[0] = {1'b0, spd[1]} > {1'b0, spd[0]} + {1'b0, dev_rng_q};
    dev_d[1] = {1'b0, spd[0]} > {1'b0, spd[1]} + {1'b0, dev_rng_q};
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sw_relay <= '0;
      dev_relay <= 2'h0;
    end
    else
    begin
      // on at setpoint, off below setpoint less hysteresis
      for (int k = 0; k < N_SW; k++)
      begin
        if (top_spd >= sw_sp_q[k])
          sw_relay[k] <= 1'b1;
        else if ({1'b0, top_spd} + {1'b0, sw_hy_q[k]} <
                 {1'b0, sw_sp_q[k]})
          sw_relay[k] <= 1'b0;
      end
      dev_relay <= dev_d;
    end
  end

  // analog codes: offset, gain, saturate at full scale
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      ao_code <= '0;
    else
    begin
      for (int k = 0; k < N_AO; k++)
      begin
        logic [15:0] src;
        logic [15:0] dif;
        logic [31:0] prod;
        // channels 0,1 tachometers; then one per pickup
        src = (k < 2) ? top_spd : spd[k % 2];
        dif = (src > ao_lo_q[k]) ? src - ao_lo_q[k] : 16'h0000;
        prod = 32'(dif) * 32'(ao_gn_q[k]);
        if (prod[31:16] > OTS_AO_MAX)
          ao_code[k] <= OTS_AO_MAX[OTS_AO_W-1:0];
        else
          ao_code[k] <= prod[OTS_AO_W+15:16];
      end
    end
  end

  // flag a max setting at or below tacho full scale times 1000/998
  always_comb
  begin
    for (int g = 0; g < 2; g++)
      warn[g] = 32'(maxs_q[g]) * OTS_REC_NUM <= 32'(tfs_q) * OTS_REC_DEN;
  end

  // sticky events, write one to clear, set wins
  assign ev[OTS_IRQ_TRIP] = (os_d & ~os_q) | (dual_d & ~dual_q);
  assign ev[OTS_IRQ_FAIL +: 2] = fail_d & ~fail_q;
  assign ev[OTS_IRQ_RST] = rst_pulse;
  assign ev[OTS_IRQ_DEV] = |(dev_d & ~dev_relay);

  always_comb
  begin
    ist_d = ist_q;
    if (reg_wr && reg_addr == OTS_IST_OFS)
      ist_d = ist_q & ~reg_wdata[OTS_IRQ_W-1:0];
    ist_d = ist_d | ev;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ist_q <= '0;
      irq <= 1'b0;
    end
    else
    begin
      ist_q <= ist_d;
      irq <= |(ist_d & imsk_q);
    end
  end

  // status word
  always_comb
  begin
    stat = 32'h0000_0000;
    stat[OTS_ST_TRIP] = ~trip_relay;
    stat[OTS_ST_OS] = os_q;
    stat[OTS_ST_DUAL] = dual_q;
    stat[OTS_ST_FAIL +: 2] = fail_q;
    stat[OTS_ST_DEV +: 2] = dev_relay;
    stat[OTS_ST_SW +: N_SW] = sw_relay;
    stat[OTS_ST_OVR] = ovr;
    stat[OTS_ST_WARN +: 2] = warn;
  end

  // read mux; unmapped offsets read zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (reg_addr)
      OTS_CTRL_OFS: rd_mux[OTS_CTRL_CFG] = cfg_mode_q;
      OTS_STAT_OFS: rd_mux = stat;
      OTS_IST_OFS: rd_mux[OTS_IRQ_W-1:0] = ist_q;
      OTS_IMSK_OFS: rd_mux[OTS_IRQ_W-1:0] = imsk_q;
      OTS_TRIP_OFS: rd_mux[15:0] = trip_sp_q;
      OTS_FAIL_OFS: rd_mux[15:0] = fail_sp_q;
      OTS_DEVR_OFS: rd_mux[15:0] = dev_rng_q;
      OTS_TFS_OFS: rd_mux[15:0] = tfs_q;
      default: rd_mux = 32'h0000_0000;
    endcase
    for (int i = 0; i < 2; i++)
    begin
      if (reg_hit(reg_addr, OTS_SPD_OFS, i))
        rd_mux[15:0] = spd[i];
      if (reg_hit(reg_addr, OTS_TEETH_OFS, i))
        rd_mux[7:0] = teeth_q[i];
      if (reg_hit(reg_addr, OTS_MAXS_OFS, i))
        rd_mux[15:0] = maxs_q[i];
    end
    for (int i = 0; i < N_SW; i++)
    begin
      if (reg_hit(reg_addr, OTS_SWSP_OFS, i))
        rd_mux[15:0] = sw_sp_q[i];
      if (reg_hit(reg_addr, OTS_SWHY_OFS, i))
        rd_mux[15:0] = sw_hy_q[i];
    end
    for (int i = 0; i < N_AO; i++)
    begin
      if (reg_hit(reg_addr, OTS_AOLO_OFS, i))
        rd_mux[15:0] = ao_lo_q[i];
      if (reg_hit(reg_addr, OTS_AOGN_OFS, i))
        rd_mux[15:0] = ao_gn_q[i];
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 32'h0000_0000;
    else
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
  end

  // checks on the trip path and alarms
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  trip_on_os_a: assert property (os_set |=> !trip_relay)
    else $error("trip relay held on overspeed");
  trip_cfg_a: assert property (cfg_mode_q |=> !trip_relay)
    else $error("trip relay held in config mode");
  ind_relay_a: assert property (trip_ind |-> !trip_relay)
    else $error("indicator set with relay energized");
  ind_clear_a: assert property ($fell(trip_ind) |->
    $past(rst_pulse) && !$past(os_set))
    else $error("trip indicator cleared without reset");
  dual_clear_a: assert property ($fell(dual_q) |->
    $past(rst_pulse) && $past(ovr))
    else $error("dual failure cleared without override");
  fail_ovr_a: assert property ($fell(fail_relay[0]) |->
    !$past(ovr))
    else $error("failure raised while overridden");
  fail_hold_a: assert property (
    !fail_relay[1] && !rst_pulse |=> !fail_relay[1])
    else $error("failure relay restored without reset");
  ovr_reset_a: assert property (
    rst_pulse && ovr |=> fail_relay == 2'h3 ##1 fail_relay == 2'h3)
    else $error("override reset left failure relay open");
  dev_low1_a: assert property (dev_d[0] |=> dev_relay[0])
    else $error("deviation relay missed");
  sw_on_a: assert property (
    top_spd >= sw_sp_q[0] |=> sw_relay[0])
    else $error("speed switch not energized");

  os_trip_c: cover property (os_set ##1 !trip_relay ##[1:50] rst_pulse);
  dual_c: cover property (dual_set ##[1:50] rst_pulse && ovr);
  ovr_rst_c: cover property (rst_pulse && ovr && fail_q != 2'h0);
  dev_c: cover property ($rose(dev_relay[1]));
endmodule : ots_top
`default_nettype wire

// File: sim/ots_pickup_model.sv
`timescale 1ns/100ps
`default_nettype none
// plant side: two gear-tooth pickups as square waves
module ots_pickup_model (
  input wire logic core_clk,
  input var int per0,
  input var int per1,
  output logic [1:0] pulse
);
  // period in core cycles; zero means shaft stopped, line rests low
  task automatic run(input int ch);
    int p;
    forever
    begin
      p = ch ? per1 : per0;
      if (p == 0)
        @(posedge core_clk);
      else
      begin
        repeat (p / 2) @(posedge core_clk);
        pulse[ch] <= 1'b1;
        repeat (p - p / 2) @(posedge core_clk);
        pulse[ch] <= 1'b0;
      end
    end
  endtask : run
  initial pulse = 2'h0;
  initial run(0);
  initial run(1);
endmodule : ots_pickup_model
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import ots_pkg::*;
  typedef struct {int p0; int p1; logic [5:0] sw; logic [1:0] dev;} ots_row_t;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic rst_sw = 1'b0;
  logic ovr_sw = 1'b1;
  logic cpu_ok = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, rv;
  logic trip_relay, trip_ind, irq;
  logic [1:0] fail_relay, dev_relay, pickup;
  logic [5:0] sw_relay;
  logic [3:0][11:0] ao_code;
  int per0 = 0;
  int per1 = 0;
  int error_cnt = 0;
  int num_checks = 0;
  // speeds at 100 teeth: 12e6 / period
  ots_row_t rows [5] = '{'{1500, 1500, 6'h03, 2'h0},
    '{1200, 1200, 6'h07, 2'h0}, '{1200, 1300, 6'h07, 2'h2},
    '{1300, 1200, 6'h07, 2'h1}, '{1000, 1000, 6'h0F, 2'h0}};
  logic [7:0] da [9] = '{OTS_TEETH_OFS, OTS_MAXS_OFS, OTS_TRIP_OFS,
    OTS_FAIL_OFS, OTS_DEVR_OFS, OTS_TFS_OFS, OTS_SWSP_OFS, OTS_SWHY_OFS,
    8'hFC};
  logic [31:0] dv [9] = '{32'(OTS_TEETH_RST), 32'(OTS_MAXS_RST),
    32'(OTS_TRIP_RST), 32'(OTS_FAIL_RST), 32'(OTS_DEVR_RST),
    32'(OTS_TFS_RST), 32'(OTS_SWSP_RST), 32'h0, 32'h0};

  // 20 MHz core clock
  always #25 core_clk = ~core_clk;

  ots_top #(.TIMEOUT_CYC(2000)) i_ots_top (.core_clk(core_clk),
    .arst_n(arst_n), .speed_pickup_in(pickup), .reset_sw_in(rst_sw),
    .override_sw_in(ovr_sw), .cpu_ok_in(cpu_ok), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .trip_relay(trip_relay), .trip_ind(trip_ind),
    .fail_relay(fail_relay), .sw_relay(sw_relay), .dev_relay(dev_relay),
    .ao_code(ao_code), .irq(irq));

  ots_pickup_model i_ots_pickup_model (.core_clk(core_clk), .per0(per0),
    .per1(per1), .pulse(pickup));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // lands just past the edge so registered outputs have settled
  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : wait_clk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  // contact must open again before the next closure counts
  task automatic reset_cmd();
    rst_sw <= 1'b1;
    wait_clk(6);
    rst_sw <= 1'b0;
    wait_clk(6);
  endtask : reset_cmd

  // period jitter of a cycle moves rpm a little, hence the window
  task automatic chk_spd(input int ch, input int per);
    int e;
    e = 12_000_000 / per;
    rd(OTS_SPD_OFS + 8'(4 * ch), rv);
    chk(32'(rv > e - 16 && rv < e + 16), 32'h1);
    chk(32'(rv[0]), 32'h0);
  endtask : chk_spd

  task automatic results();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  // hang guard
  initial
  begin
    wait_clk(90000);
    error_cnt++;
    results();
  end

  initial
  begin
    wait_clk(6);
    chk(32'({trip_relay, fail_relay}), 32'h0);
    arst_n <= 1'b1;
    for (int i = 0; i < 9; i++)
    begin
      rd(da[i], rv);
      chk(rv, dv[i]);
    end
    wr(OTS_TEETH_OFS, 32'h64);
    wr(OTS_TEETH_OFS + 8'h04, 32'h64);
    wr(OTS_TRIP_OFS, 32'h32C8);
    for (int k = 0; k < 4; k++)
      wr(OTS_SWSP_OFS + 8'(4 * k), 32'(5000 + 2000 * k));
    wr(OTS_IMSK_OFS, 32'h1);
    per0 = 1200;
    per1 = 1200;
    wait_clk(5000);
    reset_cmd();
    chk(32'({trip_relay, fail_relay}), 32'h7);
    // override opened once above failure speed
    ovr_sw <= 1'b0;
    foreach (rows[i])
    begin
      per0 = rows[i].p0;
      per1 = rows[i].p1;
      wait_clk(5000);
      chk_spd(0, rows[i].p0);
      chk_spd(1, rows[i].p1);
      chk(32'(sw_relay), 32'(rows[i].sw));
      chk(32'(dev_relay), 32'(rows[i].dev));
      chk(32'({trip_relay, fail_relay}), 32'h7);
    end
    // hysteresis keeps switch 3 on when 12000 drops to 10000 rpm
    wr(OTS_SWHY_OFS + 8'h0C, 32'h07D0);
    per0 = 1200;
    per1 = 1200;
    wait_clk(3000);
    chk(32'(sw_relay), 32'h0F);
    per0 = 1000;
    per1 = 1000;
    wait_clk(3000);
    // analog scaling at 12000 rpm; 16-bit gain, just under one
    wr(OTS_AOGN_OFS, 32'hFFFF);
    wr(OTS_AOGN_OFS + 8'h04, 32'h2000);
    wr(OTS_AOGN_OFS + 8'h08, 32'hFFFF);
    wait_clk(5);
    chk(32'(ao_code[0]), 32'hFFF);
    rv = 32'(ao_code[1]);
    chk(32'(rv > 32'h5D2 && rv < 32'h5E6), 32'h1);
    chk(32'(ao_code[2]), 32'hFFF);
    chk(32'(ao_code[3]), 32'h0);
    wr(OTS_MAXS_OFS, 32'h2328);
    wait_clk(3000);
    rd(OTS_SPD_OFS, rv);
    chk(rv, 32'h2328);
    // max 9000 sits below tacho full scale on pickup one only
    rd(OTS_STAT_OFS, rv);
    chk(32'(rv[OTS_ST_WARN +: 2]), 32'h1);
    wr(OTS_MAXS_OFS, 32'(OTS_MAXS_RST));
    // overspeed trip, interrupt and latch
    wr(OTS_IST_OFS, 32'h1F);
    wait_clk(5);
    chk(32'(irq), 32'h0);
    per0 = 900;
    per1 = 900;
    wait_clk(4000);
    chk(32'({trip_relay, trip_ind, irq}), 32'h3);
    rd(OTS_IST_OFS, rv);
    chk(32'(rv[OTS_IRQ_TRIP]), 32'h1);
    wr(OTS_IMSK_OFS, 32'h0);
    wait_clk(3);
    chk(32'(irq), 32'h0);
    wr(OTS_IMSK_OFS, 32'h1);
    wait_clk(3);
    chk(32'(irq), 32'h1);
    reset_cmd();
    chk(32'(trip_ind), 32'h1);
    per0 = 1200;
    per1 = 1200;
    wait_clk(5000);
    chk(32'({trip_relay, trip_ind}), 32'h1);
    wr(OTS_IST_OFS, 32'h1);
    wait_clk(3);
    chk(32'(irq), 32'h0);
    reset_cmd();
    chk(32'({trip_relay, trip_ind}), 32'h2);
    // single pickup loss, latched until reset
    per1 = 0;
    wait_clk(3000);
    chk(32'({trip_relay, fail_relay}), 32'h5);
    per1 = 1200;
    wait_clk(5000);
    chk(32'(fail_relay), 32'h1);
    reset_cmd();
    chk(32'(fail_relay), 32'h3);
    ovr_sw <= 1'b1;
    per0 = 0;
    wait_clk(3000);
    chk(32'(fail_relay), 32'h3);
    per0 = 1200;
    wait_clk(5000);
    ovr_sw <= 1'b0;
    // both pickups lost
    per0 = 0;
    per1 = 0;
    wait_clk(3000);
    chk(32'({trip_relay, fail_relay}), 32'h0);
    per0 = 1200;
    per1 = 1200;
    wait_clk(5000);
    reset_cmd();
    chk(32'(trip_relay), 32'h0);
    ovr_sw <= 1'b1;
    wait_clk(6);
    reset_cmd();
    chk(32'({trip_relay, fail_relay}), 32'h7);
    cpu_ok <= 1'b0;
    wait_clk(5);
    chk(32'(trip_relay), 32'h0);
    cpu_ok <= 1'b1;
    wr(OTS_CTRL_OFS, 32'h1);
    wait_clk(5);
    chk(32'(trip_relay), 32'h0);
    results();
  end
endmodule : testbench
`default_nettype wire
